// file: dsv_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Core model: halts on break or request until resumed
// ****
module dsv_core_model (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic halt_en,
  input  wire logic halt_req,
  input  wire logic resume,
  input  wire logic instruction_break_request,
  input  wire logic debug_request_to_core,
  output logic      core_debug_ack
);
  always @(posedge mclk or negedge rstn) begin
    if (!rstn)
      core_debug_ack <= 1'b0;
    else if (resume)
      core_debug_ack <= 1'b0;
    else if (halt_en && (instruction_break_request || debug_request_to_core || halt_req))
      core_debug_ack <= 1'b1;
  end
endmodule // dsv_core_model
`default_nettype wire

// file: dsv_map.vh
`ifndef DSV_MAP_VH
`define DSV_MAP_VH

// ****************************************************************
// Register access port
// ****************************************************************
`define DSV_ADDR_W        5
`define DSV_DATA_W        32
`define DSV_ADDR_CTRL     5'h00
`define DSV_ADDR_STATUS   5'h01
`define DSV_ADDR_VCATCH   5'h02

// ****************************************************************
// Control register fields
// ****************************************************************
`define DSV_CTRL_W        6
`define DSV_CTRL_RESET    6'h10
`define DSV_CTRL_ACK_BIT  0
`define DSV_CTRL_REQ_BIT  1
`define DSV_CTRL_MON_BIT  4

// ****************************************************************
// Status register fields
// ****************************************************************
`define DSV_STAT_W        10
`define DSV_STAT_ACK_BIT  0
`define DSV_STAT_REQ_BIT  1
`define DSV_STAT_IEN_BIT  2
`define DSV_STAT_SYS_BIT  3
`define DSV_STAT_ISS_BIT  4
`define DSV_STAT_RSV_BIT  5
`define DSV_STAT_CAU_LSB  6
`define DSV_STAT_CAU_MSB  9

// ****************************************************************
// Vector catch
// ****************************************************************
`define DSV_VEC_W         8
`define DSV_VEC_RESET     8'h00
`define DSV_VEC_PABT_BIT  3
`define DSV_VEC_DABT_BIT  4
`define DSV_VEC_AREA_MSB  31
`define DSV_VEC_AREA_LSB  5
`define DSV_VEC_IDX_MSB   4
`define DSV_VEC_IDX_LSB   2

// ****************************************************************
// Entry cause codes
// ****************************************************************
`define DSV_CAUSE_W       4
`define DSV_CAUSE_NONE    4'h0
`define DSV_CAUSE_BP0     4'h1
`define DSV_CAUSE_BP1     4'h2
`define DSV_CAUSE_BREAKPOINT_INSTR    4'h3
`define DSV_CAUSE_VCATCH  4'h4
`define DSV_CAUSE_EXT_BP  4'h5
`define DSV_CAUSE_WP0     4'h6
`define DSV_CAUSE_WP1     4'h7
`define DSV_CAUSE_EXT_WP  4'h8
`define DSV_CAUSE_INT_RQ  4'h9
`define DSV_CAUSE_EXT_RQ  4'ha
`define DSV_CAUSE_REENTRY 4'hb

`endif

// file: dsv_status.v
`timescale 1ns/1ps
`default_nettype none
`include "dsv_map.vh"

// Summary of operation
// - Status is ten bits, bit 5 zero
// - Read selected by low write bit
// - Bits 1:0 give synced request, acknowledge
// - Bit 2 shows core interrupt enable
// - Bit 3 shows system access complete
// - Bit 4 shows instruction set state
// - Entry cause updated on each debug entry with a recorded cause, else held
// - Entry cause readable through status register
// - Codes one through five: breakpoint kinds
// - Codes six through eleven: watchpoints, requests, reentry
// - Enabled exception vector fetch forces debug
// - Software interrupt vector fetch raises break
// - Vector trap uses no comparator units
// - Trap only during exception entry fetches
// - Plain branch into vectors never traps
// - Monitor mode masks abort vector traps
// - Monitor enable resets to one
module dsv_status (
  input  wire                    mclk,
  input  wire                    rstn,
  input  wire                    ce,
  input  wire                    tap_access,
  input  wire                    tap_write,
  input  wire [`DSV_ADDR_W-1:0]  tap_addr,
  input  wire [`DSV_DATA_W-1:0]  tap_wdata,
  output reg  [`DSV_DATA_W-1:0]  tap_rdata,
  input  wire                    external_debug_request_in,
  input  wire                    core_debug_ack,
  input  wire                    core_interrupt_enable_state,
  input  wire                    system_access_complete,
  input  wire                    instruction_set_state,
  input  wire                    fetch_valid,
  input  wire [31:0]             fetch_addr,
  input  wire                    exception_entry,
  input  wire                    entry_bp0,
  input  wire                    entry_bp1,
  input  wire                    entry_breakpoint_instr,
  input  wire                    entry_ext_bp,
  input  wire                    entry_wp0,
  input  wire                    entry_wp1,
  input  wire                    entry_ext_wp,
  input  wire                    entry_reentry,
  output wire                    debug_request_to_core,
  output wire                    debug_acknowledge,
  output wire                    instruction_break_request,
  output wire                    monitor_mode
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function addr_hit;
    input [`DSV_ADDR_W-1:0] a;
    input [`DSV_ADDR_W-1:0] b;
    begin
      addr_hit = (a == b);
    end
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [`DSV_CTRL_W-1:0]  ctrl_reg;
  reg  [`DSV_VEC_W-1:0]   vcatch_reg;
  reg  [`DSV_CAUSE_W-1:0] cause_reg;
  reg  [`DSV_CAUSE_W-1:0] cause_next;
  reg                     ack_prev_reg;
  reg                     vcatch_seen_reg;
  reg                     int_rq_seen_reg;
  reg                     ext_rq_seen_reg;
  reg  [`DSV_DATA_W-1:0]  rdata_next;
  wire [1:0]              sync_q;
  wire                    ext_rq_sync;
  wire                    ack_sync;
  wire                    entry_pulse;
  wire                    catch_hit;
  wire                    wr_en;
  wire [`DSV_STAT_W-1:0]  status_word;

  // ****************************************************************
  // Synchronisers for request and acknowledge
  // ****************************************************************
  dsv_sync #(
    .WIDTH (2)
  ) u_sync (
    .mclk  (mclk),
    .rstn  (rstn),
    .ce    (ce),
    .d_in  ({external_debug_request_in, core_debug_ack}),
    .q_out (sync_q)
  );

  assign ext_rq_sync = sync_q[1];
  assign ack_sync    = sync_q[0];

  assign debug_request_to_core = ext_rq_sync | ctrl_reg[`DSV_CTRL_REQ_BIT];
  assign debug_acknowledge     = core_debug_ack | ctrl_reg[`DSV_CTRL_ACK_BIT];
  assign monitor_mode          = ctrl_reg[`DSV_CTRL_MON_BIT];

  // ****************************************************************
  // Vector catch
  // ****************************************************************
  dsv_vcatch u_vcatch (
    .fetch_valid     (fetch_valid),
    .fetch_addr      (fetch_addr),
    .exception_entry (exception_entry),
    .vcatch_enable   (vcatch_reg),
    .monitor_enable  (ctrl_reg[`DSV_CTRL_MON_BIT]),
    .catch_hit       (catch_hit)
  );

  assign instruction_break_request = catch_hit;

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  // Read when write bit low, status ignores writes
  assign wr_en = tap_access & tap_write;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg   <= `DSV_CTRL_RESET;
      vcatch_reg <= `DSV_VEC_RESET;
    end else if (ce) begin
      if (wr_en && addr_hit(tap_addr, `DSV_ADDR_CTRL)) begin
        ctrl_reg <= tap_wdata[`DSV_CTRL_W-1:0];
      end
      if (wr_en && addr_hit(tap_addr, `DSV_ADDR_VCATCH)) begin
        vcatch_reg <= tap_wdata[`DSV_VEC_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Entry cause capture
  // ****************************************************************
  assign entry_pulse = ack_sync & ~ack_prev_reg;

  // Remember catch and request causes until entry is seen
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack_prev_reg    <= 1'b0;
      vcatch_seen_reg <= 1'b0;
      int_rq_seen_reg <= 1'b0;
      ext_rq_seen_reg <= 1'b0;
    end else if (ce) begin
      ack_prev_reg <= ack_sync;
      if (catch_hit) begin
        vcatch_seen_reg <= 1'b1;
      end else if (entry_pulse) begin
        vcatch_seen_reg <= 1'b0;
      end
      if (ctrl_reg[`DSV_CTRL_REQ_BIT] && !ack_sync) begin
        int_rq_seen_reg <= 1'b1;
      end else if (entry_pulse) begin
        int_rq_seen_reg <= 1'b0;
      end
      if (ext_rq_sync && !ack_sync) begin
        ext_rq_seen_reg <= 1'b1;
      end else if (entry_pulse) begin
        ext_rq_seen_reg <= 1'b0;
      end
    end
  end

  always @* begin
    cause_next = cause_reg;
    if (entry_pulse) begin
      if (entry_reentry) begin
        cause_next = `DSV_CAUSE_REENTRY;
      end else if (entry_bp0) begin
        cause_next = `DSV_CAUSE_BP0;
      end else if (entry_bp1) begin
        cause_next = `DSV_CAUSE_BP1;
      end else if (entry_breakpoint_instr) begin
        cause_next = `DSV_CAUSE_BREAKPOINT_INSTR;
      end else if (vcatch_seen_reg) begin
        cause_next = `DSV_CAUSE_VCATCH;
      end else if (entry_ext_bp) begin
        cause_next = `DSV_CAUSE_EXT_BP;
      end else if (entry_wp0) begin
        cause_next = `DSV_CAUSE_WP0;
      end else if (entry_wp1) begin
        cause_next = `DSV_CAUSE_WP1;
      end else if (entry_ext_wp) begin
        cause_next = `DSV_CAUSE_EXT_WP;
      end else if (int_rq_seen_reg) begin
        cause_next = `DSV_CAUSE_INT_RQ;
      end else if (ext_rq_seen_reg) begin
        cause_next = `DSV_CAUSE_EXT_RQ;
      end else begin
        cause_next = cause_reg;
      end
    end
  end

  // Cause holds until next entry or reset
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cause_reg <= `DSV_CAUSE_NONE;
    end else if (ce) begin
      cause_reg <= cause_next;
    end
  end

  // ****************************************************************
  // Status word and read data
  // ****************************************************************
  assign status_word = {cause_reg,
                        1'b0,
                        instruction_set_state,
                        system_access_complete,
                        core_interrupt_enable_state,
                        ext_rq_sync, ack_sync};

  always @* begin
    rdata_next = {`DSV_DATA_W{1'b0}};
    case (tap_addr)
      `DSV_ADDR_CTRL: begin
        rdata_next[`DSV_CTRL_W-1:0] = ctrl_reg;
      end
      `DSV_ADDR_STATUS: begin
        rdata_next[`DSV_STAT_W-1:0] = status_word;
      end
      `DSV_ADDR_VCATCH: begin
        rdata_next[`DSV_VEC_W-1:0] = vcatch_reg;
      end
      default: begin
        rdata_next = {`DSV_DATA_W{1'b0}};
      end
    endcase
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tap_rdata <= {`DSV_DATA_W{1'b0}};
    end else if (ce && tap_access && !tap_write) begin
      tap_rdata <= rdata_next;
    end
  end

endmodule // dsv_status

`default_nettype wire

// file: dsv_status_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsv_map.vh"
// ****
// Status and trap checker
// ****
module dsv_status_chk (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        tap_access,
  input wire logic        tap_write,
  input wire logic [4:0]  tap_addr,
  input wire logic [31:0] tap_rdata,
  input wire logic        external_debug_request_in,
  input wire logic        core_debug_ack,
  input wire logic        core_interrupt_enable_state,
  input wire logic        system_access_complete,
  input wire logic        instruction_set_state,
  input wire logic        fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic        exception_entry,
  input wire logic        instruction_break_request,
  input wire logic        monitor_mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire rd_any = ce && tap_access && !tap_write;
  wire rd_st  = rd_any && tap_addr == `DSV_ADDR_STATUS;
  wire fx     = fetch_valid && exception_entry;
  wire [2:0] vi = fetch_addr[4:2];

  rsv_zero_a: assert property (rd_st |=> tap_rdata[31:10] == 22'h0 && !tap_rdata[5])
    else $error("status reserved bits not zero");
  unmapped_zero_a: assert property (rd_any && tap_addr > 5'h02 |=> tap_rdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!rd_any |=> $stable(tap_rdata))
    else $error("read data moved without a read");
  sync_bits_a: assert property (rd_st && $past(ce) && $past(ce, 2) && $past(rstn, 3) |=>
    tap_rdata[1:0] == {$past(external_debug_request_in, 3), $past(core_debug_ack, 3)})
    else $error("synced status bits wrong");
  live_bits_a: assert property (rd_st |=> tap_rdata[4:2] ==
    $past({instruction_set_state, system_access_complete, core_interrupt_enable_state}))
    else $error("live status bits wrong");
  no_exc_trap_a: assert property (!fx |-> !instruction_break_request)
    else $error("trap outside exception entry");
  out_area_a: assert property (fetch_addr[31:5] != 27'h0 |-> !instruction_break_request)
    else $error("trap outside vector area");
  mon_mask_a: assert property (monitor_mode && (vi == 3'h3 || vi == 3'h4)
    |-> !instruction_break_request)
    else $error("abort vector trapped in monitor mode");
  mon_reset_a: assert property (!$past(rstn) |-> monitor_mode)
    else $error("monitor mode not set after reset");

  cover property (rd_st);
  cover property (fx && instruction_break_request);
  cover property (monitor_mode && fx && vi == 3'h4);
endmodule // dsv_status_chk

bind dsv_status dsv_status_chk u_dsv_status_chk (.*);
`default_nettype wire

// file: dsv_status_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsv_map.vh"
module dsv_status_test;
  logic mclk = 1'b0, rstn = 1'b0, ce = 1'b1, tap_access = 1'b0, tap_write = 1'b0;
  logic [4:0] tap_addr = 5'h00;
  logic [31:0] tap_wdata = 32'h0, fetch_addr = 32'h0, d;
  logic external_debug_request_in = 1'b0, core_interrupt_enable_state = 1'b0;
  logic system_access_complete = 1'b0, instruction_set_state = 1'b0;
  logic fetch_valid = 1'b0, exception_entry = 1'b0;
  logic halt_en = 1'b1, halt_req = 1'b0, resume = 1'b0;
  logic [7:0] ent = 8'h00;
  logic [3:0] code [0:7] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'hb};
  wire [31:0] tap_rdata;
  wire core_debug_ack, debug_request_to_core, debug_acknowledge;
  wire instruction_break_request, monitor_mode;
  wire entry_bp0, entry_bp1, entry_breakpoint_instr, entry_ext_bp;
  wire entry_wp0, entry_wp1, entry_ext_wp, entry_reentry;
  integer fails = 0, n_compared = 0, cycles = 0, i, j;
  assign {entry_reentry, entry_ext_wp, entry_wp1, entry_wp0} = ent[7:4];
  assign {entry_ext_bp, entry_breakpoint_instr, entry_bp1, entry_bp0} = ent[3:0];

  always #12.5 mclk = ~mclk;
  dsv_status u_dsv_status (.*);
  dsv_core_model u_dsv_core_model (.*);

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      test_done;
    end
  end

  task chk(input [31:0] seen, input [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task acc(input w, input [4:0] a, input [31:0] v);
    @(negedge mclk);
    tap_access = 1'b1;
    tap_write = w;
    tap_addr = a;
    tap_wdata = v;
    @(negedge mclk);
    tap_access = 1'b0;
    d = tap_rdata;
  endtask

  task fetch(input [31:0] a, input x, input exp);
    @(negedge mclk);
    fetch_valid = 1'b1;
    fetch_addr = a;
    exception_entry = x;
    #1 chk(instruction_break_request, exp);
  endtask

  // Wait for halt, check cause and acknowledge, resume, check cause held
  task enter(input [3:0] c);
    integer k;
    k = 0;
    while (core_debug_ack !== 1'b1 && k < 20) begin
      @(negedge mclk);
      k = k + 1;
    end
    repeat (4) @(negedge mclk);
    ent = 8'h00;
    halt_req = 1'b0;
    external_debug_request_in = 1'b0;
    acc(1'b0, `DSV_ADDR_STATUS, 32'h0);
    chk(d[9:6], c);
    chk({d[0], debug_acknowledge}, 2'b11);
    acc(1'b1, `DSV_ADDR_CTRL, 32'h0);
    resume = 1'b1;
    @(negedge mclk);
    resume = 1'b0;
    repeat (6) @(negedge mclk);
    acc(1'b0, `DSV_ADDR_STATUS, 32'h0);
    chk(d[9:6], c);
  endtask

  initial begin
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    acc(1'b0, `DSV_ADDR_CTRL, 32'h0);
    chk(d, 32'h10);
    chk(monitor_mode, 1'b1);
    acc(1'b0, `DSV_ADDR_VCATCH, 32'h0);
    chk(d, 32'h0);
    acc(1'b1, `DSV_ADDR_STATUS, 32'hffffffff);
    acc(1'b0, `DSV_ADDR_STATUS, 32'h0);
    chk(d, 32'h0);
    acc(1'b0, 5'h1f, 32'h0);
    chk(d, 32'h0);
    $display("test reset done");
    halt_en = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      {instruction_set_state, system_access_complete, core_interrupt_enable_state} = i[2:0];
      acc(1'b0, `DSV_ADDR_STATUS, 32'h0);
      chk(d[4:2], i[2:0]);
    end
    external_debug_request_in = 1'b1;
    repeat (3) @(negedge mclk);
    acc(1'b0, `DSV_ADDR_STATUS, 32'h0);
    chk({d[1:0], debug_request_to_core}, 3'b101);
    external_debug_request_in = 1'b0;
    repeat (4) @(negedge mclk);
    halt_en = 1'b1;
    $display("test live bits done");
    for (i = 0; i < 8; i = i + 1) begin
      ent = 8'h01 << i;
      halt_req = 1'b1;
      enter(code[i]);
    end
    acc(1'b1, `DSV_ADDR_CTRL, 32'h2);
    enter(`DSV_CAUSE_INT_RQ);
    external_debug_request_in = 1'b1;
    enter(`DSV_CAUSE_EXT_RQ);
    acc(1'b1, `DSV_ADDR_VCATCH, 32'h4);
    fetch(32'h8, 1'b1, 1'b1);
    @(negedge mclk);
    fetch_valid = 1'b0;
    enter(`DSV_CAUSE_VCATCH);
    $display("test causes done");
    halt_en = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      acc(1'b1, `DSV_ADDR_VCATCH, 32'h1 << i);
      for (j = 0; j < 8; j = j + 1) begin
        fetch(j * 4, 1'b1, i == j);
        fetch(j * 4, 1'b0, 1'b0);
      end
    end
    acc(1'b1, `DSV_ADDR_VCATCH, 32'h18);
    acc(1'b1, `DSV_ADDR_CTRL, 32'h10);
    fetch(32'hc, 1'b1, 1'b0);
    fetch(32'h10, 1'b1, 1'b0);
    acc(1'b1, `DSV_ADDR_CTRL, 32'h0);
    chk(monitor_mode, 1'b0);
    fetch(32'hc, 1'b1, 1'b1);
    fetch(32'h10, 1'b1, 1'b1);
    @(negedge mclk);
    fetch_valid = 1'b0;
    $display("test vector catch done");
    test_done;
  end
endmodule // dsv_status_test
`default_nettype wire

// file: dsv_sync.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Two stage level synchroniser
// ****************************************************************
module dsv_sync #(
  parameter WIDTH = 2
) (
  input  wire             mclk,
  input  wire             rstn,
  input  wire             ce,
  input  wire [WIDTH-1:0] d_in,
  output wire [WIDTH-1:0] q_out
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          stage1_reg[i] <= 1'b0;
          stage2_reg[i] <= 1'b0;
        end else if (ce) begin
          stage1_reg[i] <= d_in[i];
          stage2_reg[i] <= stage1_reg[i];
        end
      end
    end
  endgenerate

  assign q_out = stage2_reg;

endmodule // dsv_sync

`default_nettype wire

// file: dsv_vcatch.v
`timescale 1ns/1ps
`default_nettype none
`include "dsv_map.vh"

// ****************************************************************
// Vector fetch trap
// ****************************************************************
module dsv_vcatch (
  input  wire                  fetch_valid,
  input  wire [31:0]           fetch_addr,
  input  wire                  exception_entry,
  input  wire [`DSV_VEC_W-1:0] vcatch_enable,
  input  wire                  monitor_enable,
  output wire                  catch_hit
);

  wire                  in_area;
  wire [2:0]            vec_idx;
  wire [`DSV_VEC_W-1:0] eff_enable;

  // Only fetches inside the vector table qualify
  assign in_area = ~|fetch_addr[`DSV_VEC_AREA_MSB:`DSV_VEC_AREA_LSB];
  // Bit index is the vector address divided by four
  assign vec_idx = fetch_addr[`DSV_VEC_IDX_MSB:`DSV_VEC_IDX_LSB];

  // Abort vectors masked while monitor debugging is chosen
  assign eff_enable = vcatch_enable &
                      ~({`DSV_VEC_W{monitor_enable}} &
                        ((`DSV_VEC_W'h1 << `DSV_VEC_PABT_BIT) |
                         (`DSV_VEC_W'h1 << `DSV_VEC_DABT_BIT)));

  // Own decode, no comparator unit is used; branches are ignored
  assign catch_hit = fetch_valid & exception_entry & in_area &
                     eff_enable[vec_idx];

endmodule // dsv_vcatch

`default_nettype wire
